// [inc/prd_pkg.sv]
// parallel reference decoder: shared constants and types
package prd_pkg;
  localparam int unsigned DATA_W        = 16;
  localparam logic [2:0]  FMT_BCD_PCT1  = 3'h0;
  localparam logic [2:0]  FMT_BCD_HZ001 = 3'h5;
  localparam logic [2:0]  FMT_BCD5      = 3'h6;
  localparam logic [2:0]  FMT_BINARY    = 3'h7;
  localparam logic [2:0]  FMT_RESET     = 3'h0;
  localparam logic [15:0] SCALE_RESET   = 16'h0000;
  localparam logic [15:0] SCALE_RPM_MIN = 16'h0002;
  localparam logic [15:0] SCALE_USER    = 16'h0028;
  localparam logic [15:0] SCALE_MAX     = 16'h9c3f;
  localparam logic [1:0]  SRC_OPTION    = 2'h3;
  localparam logic [31:0] ADDR_CTRL     = 32'h0000_0000;
  localparam logic [31:0] ADDR_SCALE    = 32'h0000_0004;
  localparam logic [31:0] ADDR_REF      = 32'h0000_0008;
  localparam logic [31:0] ADDR_STATUS   = 32'h0000_000c;
  localparam logic [31:0] ADDR_FULL12   = 32'h0000_0010;
  localparam logic [31:0] ADDR_FULL16   = 32'h0000_0014;
  localparam logic [15:0] FULL12_RESET  = 16'h0fff;
  localparam logic [15:0] FULL16_RESET  = 16'h7530;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

  typedef enum logic [1:0] {
    PRD_UNIT_FORMAT,
    PRD_UNIT_RPM,
    PRD_UNIT_USER
  } prd_unit_t;

  typedef struct packed {
    logic [DATA_W-1:0] data;
    logic              sign;
    logic              strobe;
  } prd_pins_t;

  typedef struct packed {
    logic signed [19:0] value;
    logic               valid;
    logic               bad_digit;
  } prd_dec_t;
endpackage

// [src/prd_decode.sv]
// parallel reference decoder: combinational word decoder
`timescale 1ns/10ps
module prd_decode
  import prd_pkg::*;
(
  input  wire logic [DATA_W-1:0] data,
  input  wire logic              sign,
  input  wire logic [2:0]        fmt,
  input  wire logic              wide,
  input  wire logic              narrow_board,
  input  wire logic              force_bcd,
  output prd_dec_t               dec
);
  function automatic logic [3:0] digit_at(input logic [DATA_W-1:0] d, input int idx);
    digit_at = d[idx*4 +: 4];
  endfunction

  logic [19:0] mag;
  logic        bad;
  logic        ok;
  logic [3:0]  dg [0:3];

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_dig
      assign dg[g] = digit_at(data, g);
    end
  endgenerate

  always_comb begin
    mag = 20'h00000;
    bad = 1'b0;
    ok  = 1'b1;
    if (fmt == FMT_BINARY && !force_bcd) begin
      if (narrow_board) begin
        mag = {12'h000, data[7:0]};
      end else if (wide) begin
        mag = {4'h0, data};
      end else begin
        mag = {8'h00, data[11:0]};
      end
    end else if (fmt == FMT_BCD5 && !force_bcd) begin
      // five digits, sign pin and pin 15 carry the top two-bit digit
      if (narrow_board || !wide) begin
        ok = 1'b0;
      end else begin
        // pin 0 weighs 2, so every digit sits one bit lower than in 4-digit mode
        bad = (data[2:0] < 3'h1) || (data[2:0] > 3'h4) || (data[6:3] > 4'h9)
              || (data[10:7] > 4'h9) || (data[14:11] > 4'h9);
        mag = 20'(data[2:0]) * 20'd2
              + 20'(data[6:3]) * 20'd10 + 20'(data[10:7]) * 20'd100
              + 20'(data[14:11]) * 20'd1000
              + 20'({sign, data[15]}) * 20'd10000;
      end
    end else if (fmt > FMT_BCD5 && !force_bcd) begin
      ok = 1'b0;
    end else if (narrow_board) begin
      bad = (dg[0] > 4'h9);
      mag = 20'(dg[0]) + 20'(dg[1]) * 20'd10;
    end else begin
      bad = (dg[0] > 4'h9) || (dg[1] > 4'h9) || (dg[2] > 4'h9)
            || (wide && dg[3] > 4'h9);
      mag = 20'(dg[0]) + 20'(dg[1]) * 20'd10 + 20'(dg[2]) * 20'd100;
      if (wide) begin
        mag = mag + 20'(dg[3]) * 20'd1000;
      end
    end
  end

  always_comb begin
    dec.bad_digit = bad;
    dec.valid     = ok && !bad;
    // signed modes apply the sign pin; five-digit mode uses it as data
    if (sign && !(fmt == FMT_BCD5 && !force_bcd)) begin
      dec.value = -$signed(mag);
    end else begin
      dec.value = $signed(mag);
    end
  end
endmodule

// [src/prd_top.sv]
// parallel reference decoder: pin capture, settings registers, axi4-lite slave
//
// How it works
// - wide board takes up to sixteen data bits
// - narrow board takes eight data bits
// - format 0..7, default 0; 0-2 percent BCD, 3-5 hertz BCD
// - format 6 five-digit BCD in 0.01 Hz, wide board with 16-bit width only
// - scaling 2 or more forces BCD, units from scaling
// - scaling 0 hertz, 1 percent; range 0..39999, default 0
// - scaling 2..39 is pole count, units in rpm
// - scaling 40..39999 user units, four digits full scale, fifth decimals
// - binary 12-bit: bits 0..11 signed
// - binary 16-bit: adds bits 12..15
// - 12-bit BCD: three digits, 1-2-4-8 weights, least digit first
// - 16-bit BCD: fourth digit from upper pins
// - five-digit: 2-4-8 first digit, three full, sign pin and pin 15 as last
// - binary all ones gives full speed
// - 12-bit 4095 counts, 16-bit 30000 counts is 100 percent
`timescale 1ns/10ps
module prd_top
  import prd_pkg::*;
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [DATA_W-1:0] ref_data,
  input  wire logic              ref_sign,
  input  wire logic              ref_strobe,
  input  wire logic              word_width_switch,
  input  wire logic              narrow_board,
  input  wire logic [31:0]       s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [31:0]       s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output logic signed [19:0]     speed_reference,
  output logic                   full_speed,
  output logic                   reference_active
);
  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  prd_pins_t pins_s1;
  prd_pins_t pins_s2;
  logic      width_s1;
  logic      width_s2;
  logic      nb_s1;
  logic      nb_s2;
  logic      strobe_d;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pins_s1  <= '0;
      pins_s2  <= '0;
      width_s1 <= 1'b0;
      width_s2 <= 1'b0;
      nb_s1    <= 1'b0;
      nb_s2    <= 1'b0;
    end else begin
      pins_s1  <= '{data: ref_data, sign: ref_sign, strobe: ref_strobe};
      pins_s2  <= pins_s1;
      width_s1 <= word_width_switch;
      width_s2 <= width_s1;
      nb_s1    <= narrow_board;
      nb_s2    <= nb_s1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      strobe_d <= 1'b0;
    end else begin
      strobe_d <= pins_s2.strobe;
    end
  end

  // two-stage sync on data and strobe keeps them aligned
  logic capture;
  assign capture = pins_s2.strobe && !strobe_d;

  ////////////////////////////////////////////////////////////////////////
  // settings
  logic [1:0]  reference_source_select;
  logic [2:0]  digital_input_format;
  logic [15:0] display_scaling;
  logic [15:0] full12;
  logic [15:0] full16;
  prd_unit_t   unit_mode;
  logic        force_bcd;

  always_comb begin
    if (display_scaling >= SCALE_USER) begin
      unit_mode = PRD_UNIT_USER;
    end else if (display_scaling >= SCALE_RPM_MIN) begin
      unit_mode = PRD_UNIT_RPM;
    end else begin
      unit_mode = PRD_UNIT_FORMAT;
    end
  end

  assign force_bcd = (unit_mode != PRD_UNIT_FORMAT);

  ////////////////////////////////////////////////////////////////////////
  // decode and hold
  prd_dec_t dec;

  prd_decode u_decode (
    .data         (pins_s2.data),
    .sign         (pins_s2.sign),
    .fmt          (digital_input_format),
    .wide         (width_s2),
    .narrow_board (nb_s2),
    .force_bcd    (force_bcd),
    .dec          (dec)
  );

  logic is_binary;
  logic all_ones;
  assign is_binary = (digital_input_format == FMT_BINARY) && !force_bcd;
  always_comb begin
    if (nb_s2) begin
      all_ones = &pins_s2.data[7:0];
    end else if (width_s2) begin
      all_ones = &pins_s2.data;
    end else begin
      all_ones = &pins_s2.data[11:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      speed_reference <= '0;
      full_speed      <= 1'b0;
    end else if (capture && dec.valid) begin
      // a refused word leaves the old reference in place
      speed_reference <= dec.value;
      full_speed      <= is_binary && all_ones;
    end
  end

  // only meaningful once the host routes the option board in
  assign reference_active = (reference_source_select == SRC_OPTION);

  ////////////////////////////////////////////////////////////////////////
  // axi4-lite write
  logic        aw_held;
  logic        w_held;
  logic [31:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        do_write;
  logic        clr_bad;

  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign do_write      = aw_held && w_held && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= '0;
      w_data  <= '0;
      w_strb  <= '0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (do_write) begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (do_write) begin
        w_held <= 1'b0;
      end
    end
  end

  function automatic logic mapped(input logic [31:0] a);
    mapped = (a == ADDR_CTRL) || (a == ADDR_SCALE) || (a == ADDR_REF)
             || (a == ADDR_STATUS) || (a == ADDR_FULL12) || (a == ADDR_FULL16);
  endfunction

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= mapped(aw_addr) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  assign clr_bad = do_write && aw_addr == ADDR_STATUS && w_strb[0] && w_data[1];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      reference_source_select <= 2'h0;
      digital_input_format    <= FMT_RESET;
      display_scaling         <= SCALE_RESET;
      full12                  <= FULL12_RESET;
      full16                  <= FULL16_RESET;
    end else if (do_write) begin
      if (aw_addr == ADDR_CTRL && w_strb[0]) begin
        digital_input_format    <= w_data[2:0];
        reference_source_select <= w_data[5:4];
      end
      // out-of-range scaling is refused, old value kept
      if (aw_addr == ADDR_SCALE && &w_strb[1:0] && w_data[15:0] <= SCALE_MAX) begin
        display_scaling <= w_data[15:0];
      end
      if (aw_addr == ADDR_FULL12 && &w_strb[1:0]) begin
        full12 <= w_data[15:0];
      end
      if (aw_addr == ADDR_FULL16 && &w_strb[1:0]) begin
        full16 <= w_data[15:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // axi4-lite read
  logic [31:0] rd_word;
  logic        bad_flag;

  // a new bad word in the clearing cycle keeps the flag set
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bad_flag <= 1'b0;
    end else if (capture && !dec.valid) begin
      bad_flag <= 1'b1;
    end else if (clr_bad) begin
      bad_flag <= 1'b0;
    end
  end

  always_comb begin
    case (s_axi_araddr)
      ADDR_CTRL:   rd_word = {26'h0, reference_source_select, 1'b0, digital_input_format};
      ADDR_SCALE:  rd_word = {16'h0, display_scaling};
      ADDR_REF:    rd_word = {{12{speed_reference[19]}}, speed_reference};
      ADDR_STATUS: rd_word = {28'h0, unit_mode, bad_flag, full_speed};
      ADDR_FULL12: rd_word = {16'h0, full12};
      ADDR_FULL16: rd_word = {16'h0, full16};
      default:     rd_word = 32'h0000_0000;
    endcase
  end

  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_word;
      s_axi_rresp  <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule

// [tb/prd_props.sv]
// checker for the reference decoder top
`timescale 1ns/10ps
module prd_props
  import prd_pkg::*;
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        ref_strobe,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic signed [19:0] speed_reference,
  input wire logic        full_speed
);
  logic [3:0] low_cnt;
  // cycles since strobe was last high, saturating
  always_ff @(posedge aclk) begin
    if (!aresetn || ref_strobe) begin
      low_cnt <= 4'h0;
    end else if (low_cnt != 4'hf) begin
      low_cnt <= low_cnt + 4'h1;
    end
  end
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  a_ref_hold: assert property (low_cnt > 4'h6 |-> $stable(speed_reference))
    else $error("reference moved without strobe");
  a_full_cause: assert property ($rose(full_speed) |-> low_cnt < 4'h6)
    else $error("full speed rose without strobe");
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while busy");
  a_r_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_b_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:3] s_axi_bvalid) else $error("write answer late");
  a_err_zero: assert property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR |-> s_axi_rdata == 32'h0)
    else $error("error read carries data");
  a_aw_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
endmodule

bind prd_top prd_props u_props (.aclk, .aresetn, .ref_strobe, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .speed_reference,
  .full_speed);

// [tb/prd_ctrl_model.sv]
// external controller that drives the parallel reference pins
`timescale 1ns/10ps
module prd_ctrl_model
  import prd_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        go,
  input  wire logic [15:0] word,
  input  wire logic        sgn,
  output prd_pins_t        pins,
  output logic             done
);
  initial begin
    pins = '0;
    done = 1'b0;
    forever begin
      @(posedge aclk);
      if (go) begin
        pins.data <= word;
        pins.sign <= sgn;
        repeat (4) @(posedge aclk);
        pins.strobe <= 1'b1;
        repeat (3) @(posedge aclk);
        pins.strobe <= 1'b0;
        repeat (2) @(posedge aclk);
        // released lines float: show the inverse, not the old word
        pins.data <= ~word;
        pins.sign <= ~sgn;
        repeat (6) @(posedge aclk);
        done <= 1'b1;
        @(posedge aclk);
        done <= 1'b0;
      end
    end
  end
endmodule

// [tb/tb_prd_top.sv]
// self-checking bench for the reference decoder
`timescale 1ns/10ps
module tb_prd_top
  import prd_pkg::*;
;
  `define CHK(n, e, a) begin checked++; if ((a) !== (e)) begin err_count++; \
    $display("CHECK FAILED %s exp %0h got %0h", n, e, a); end end
  logic        aclk, bvalid, rvalid, done, act, full, awready, wready, arready;
  logic        aresetn = 1'b0, go = 1'b0, sgn = 1'b0, wsw = 1'b0, nb = 1'b0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [1:0]  bresp, rresp, rr;
  logic [15:0] word = 16'h0;
  logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata, rd_v;
  logic signed [19:0] spd;
  prd_pins_t   pins;
  int          err_count = 0, checked = 0;

  prd_ctrl_model u_ctrl (.aclk, .go, .word, .sgn, .pins, .done);
  prd_top dut (.aclk, .aresetn, .ref_data(pins.data), .ref_sign(pins.sign),
    .ref_strobe(pins.strobe), .word_width_switch(wsw), .narrow_board(nb),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .speed_reference(spd), .full_speed(full), .reference_active(act));

  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] ctl(input logic [2:0] f);
    return {26'h0, SRC_OPTION, 1'b0, f};
  endfunction
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid && n < 50);
    bready <= 1'b0;
    if (n >= 50) err_count++;
  endtask
  task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (!rvalid && n < 50);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    if (n >= 50) err_count++;
  endtask
  task automatic rc(input logic [31:0] a, input logic [31:0] m, input logic [31:0] e);
    rd(a, rd_v, rr);
    `CHK("register", e, rd_v & m)
  endtask
  task automatic sp(input logic [15:0] w, input logic s, input logic [19:0] e);
    int n;
    n = 0;
    @(posedge aclk);
    word <= w;
    sgn <= s;
    go <= 1'b1;
    @(posedge aclk);
    go <= 1'b0;
    do begin
      @(posedge aclk);
      n++;
    end while (!done && n < 40);
    if (n >= 40) err_count++;
    `CHK("speed", e, spd)
  endtask
  task automatic end_of_test();
    $display("comparisons %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rc(ADDR_CTRL, 32'hff, 32'h0);
    rc(ADDR_SCALE, 32'hffff, 32'h0);
    rc(ADDR_FULL12, 32'hffff, 32'hfff);
    rc(ADDR_FULL16, 32'hffff, 32'h7530);
    rd(32'h20, rd_v, rr);
    `CHK("resp", RESP_SLVERR, rr)
    `CHK("active", 1'b0, act)
    wr(ADDR_CTRL, ctl(FMT_BINARY));
    `CHK("active", 1'b1, act)
    sp(16'h0fff, 1'b0, 20'h00fff);
    `CHK("full", 1'b1, full)
    nb <= 1'b1;
    sp(16'h0fff, 1'b0, 20'h000ff);
    nb <= 1'b0;
    wsw <= 1'b1;
    sp(16'h7530, 1'b1, -20'sh07530);
    `CHK("full", 1'b0, full)
    for (int f = 0; f < 6; f++) begin
      wr(ADDR_CTRL, ctl(f[2:0]));
      sp(16'h1456, 1'b1, -20'sh005b0);
    end
    wsw <= 1'b0;
    sp(16'hf987, 1'b0, 20'h003db);
    sp(16'h0a12, 1'b0, 20'h003db);
    rc(ADDR_STATUS, 32'h2, 32'h2);
    wr(ADDR_STATUS, 32'h2);
    rc(ADDR_STATUS, 32'h2, 32'h0);
    wr(ADDR_CTRL, ctl(FMT_BCD5));
    sp(16'h0246, 1'b0, 20'h003db);
    rc(ADDR_STATUS, 32'h2, 32'h2);
    wr(ADDR_SCALE, 32'h9c40);
    rc(ADDR_SCALE, 32'hffff, 32'h0);
    wr(ADDR_SCALE, {16'h0, SCALE_MAX});
    rc(ADDR_SCALE, 32'hffff, 32'h9c3f);
    rc(ADDR_STATUS, 32'hc, 32'h8);
    wr(ADDR_SCALE, 32'h5);
    rc(ADDR_STATUS, 32'hc, 32'h4);
    wr(ADDR_CTRL, ctl(FMT_BINARY));
    wsw <= 1'b1;
    sp(16'h0123, 1'b0, 20'h0007b);
    wr(ADDR_SCALE, 32'h1);
    rc(ADDR_STATUS, 32'hc, 32'h0);
    repeat (10) @(posedge aclk);
    `CHK("hold", 20'h0007b, spd)
    wr(ADDR_CTRL, ctl(FMT_BCD5));
    sp(16'h91a3, 1'b1, 20'h07e5a);
    sp(16'h91a0, 1'b0, 20'h07e5a);
    wr(ADDR_FULL12, 32'h0123);
    rc(ADDR_FULL12, 32'hffff, 32'h0123);
    end_of_test();
  end
  initial begin
    repeat (20000) @(posedge aclk);
    err_count++;
    end_of_test();
  end
endmodule
